// file: shared/srs_pkg.sv
// constants and types shared by the subtract/rotate/sleep execution logic
package srs_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic DIGIT_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic POWERDOWN_RST = 1'b1;

  // ==========================================================================
  // field values
  localparam logic DEST_WREG = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic SLEEP_TIMEOUT = 1'b1;
  localparam logic SLEEP_POWERDOWN = 1'b0;
  localparam logic NO_BORROW = 1'b1;

  // ==========================================================================
  // operations and core states
  typedef enum logic [2:0] {
    nop_op,
    rotate_right_carry_op,
    sub_from_literal_op,
    sub_from_file_op,
    sub_with_borrow_op,
    sleep_op
  } op_e;

  typedef enum logic {
    RUN,
    ASLEEP
  } state_e;

endpackage

// file: shared/alu_if.sv
// operand and result bundle between the execution core and its datapath
`timescale 1ns/1ps
interface alu_if;
  import srs_pkg::*;
  logic [DATA_W-1:0] opA;
  logic [DATA_W-1:0] opB;
  logic carryIn;
  logic rotate;
  logic [DATA_W-1:0] result;
  logic carryOut;
  logic digitOut;
  logic zeroOut;

  modport core (output opA, output opB, output carryIn, output rotate,
                input result, input carryOut, input digitOut, input zeroOut);
  modport alu (input opA, input opB, input carryIn, input rotate,
               output result, output carryOut, output digitOut, output zeroOut);
endinterface

// file: logic/sub_rot_alu.sv
// combinational subtract and rotate-through-carry datapath
`timescale 1ns/1ps
module sub_rot_alu
  import srs_pkg::*;
(
  alu_if.alu bus
);

  logic [DATA_W:0] full;
  logic [NIB_W:0] low;

  // ==========================================================================
  // a - b done as a + ~b + carry, so carry in acts as not-borrow
  always_comb begin
    full = {1'b0, bus.opA} + {1'b0, ~bus.opB} + {{DATA_W{1'b0}}, bus.carryIn};
    low = {1'b0, bus.opA[NIB_W-1:0]} + {1'b0, ~bus.opB[NIB_W-1:0]}
          + {{NIB_W{1'b0}}, bus.carryIn};
    if (bus.rotate) begin
      // old carry enters the top, bottom bit leaves as carry
      bus.result = {bus.carryIn, bus.opA[DATA_W-1:1]};
      bus.carryOut = bus.opA[0];
    end else begin
      bus.result = full[DATA_W-1:0];
      bus.carryOut = full[DATA_W];
    end
    bus.digitOut = low[NIB_W];
    bus.zeroOut = (bus.result == ZERO_BYTE);
  end

endmodule // sub_rot_alu

// file: logic/subtract_rotate_sleep_exec.sv
// execution core for rotate-right, the three subtractions and sleep
`timescale 1ns/1ps

// How it works
// - rotate right moves the file value down one bit, old carry into bit 7, bit 0 out as carry.
// - the rotate result goes to the working register for destination 0, else to the file.
// - subtract-from-literal writes literal minus working register to it, updating all three flags.
// - register subtract forms file minus working register; carry clears when W exceeds it.
// - the register subtract result goes to W for destination 0, else back to the file.
// - subtract with borrow also takes away the inverted carry and updates all three flags.
// - the borrow subtract result goes to W for destination 0, else back to the file.
// - sleep clears the power-down flag and sets the time-out flag.
// - sleep clears the watchdog counter and its prescaler.
// - sleep puts the core into low-power sleep with the oscillator stopped.
module subtract_rotate_sleep_exec
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic opValid,
  input wire op_e opCode,
  input wire logic destBit,
  input wire logic [ADDR_W-1:0] fileAddr,
  input wire logic [DATA_W-1:0] fileData,
  input wire logic [DATA_W-1:0] literal,
  input wire logic wakeReq,
  output logic [DATA_W-1:0] wReg,
  output logic carryFlag,
  output logic digit_carry_flag,
  output logic zeroFlag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic fileWrEn,
  output logic [ADDR_W-1:0] fileWrAddr,
  output logic [DATA_W-1:0] fileWrData,
  output logic watchdogClear,
  output logic prescalerClear,
  output logic sleepMode,
  output logic oscStop
);

  alu_if alu ();

  sub_rot_alu u_alu (
    .bus(alu.alu)
  );

  state_e state_r, state_nxt;
  logic [DATA_W-1:0] w_r, w_nxt;
  logic c_r, c_nxt, digit_r, digit_nxt, z_r, z_nxt;
  logic to_r, to_nxt, pdn_r, pdn_nxt;
  logic wrEn_r, wrEn_nxt;
  logic [ADDR_W-1:0] wrAddr_r, wrAddr_nxt;
  logic [DATA_W-1:0] wrData_r, wrData_nxt;
  logic wdClr_r, wdClr_nxt, preClr_r, preClr_nxt;
  logic take;
  logic isSub;

  // ==========================================================================
  // operand steering; ops arriving while asleep are dropped
  assign take = opValid && (state_r == RUN);
  assign isSub = (opCode == sub_from_literal_op) || (opCode == sub_from_file_op)
                 || (opCode == sub_with_borrow_op);
  assign alu.opA = (opCode == sub_from_literal_op) ? literal : fileData;
  assign alu.opB = w_r;
  assign alu.rotate = (opCode == rotate_right_carry_op);
  // plain subtracts carry in one, borrow subtract uses the stored carry
  assign alu.carryIn = (opCode == sub_from_literal_op || opCode == sub_from_file_op)
                       ? NO_BORROW : c_r;

  // ==========================================================================
  // next-state for the whole core
  always_comb begin
    state_nxt = state_r;
    w_nxt = w_r;
    c_nxt = c_r;
    digit_nxt = digit_r;
    z_nxt = z_r;
    to_nxt = to_r;
    pdn_nxt = pdn_r;
    wrEn_nxt = 1'b0;
    wrAddr_nxt = wrAddr_r;
    wrData_nxt = wrData_r;
    wdClr_nxt = 1'b0;
    preClr_nxt = 1'b0;
    unique case (state_r)
      RUN: begin
        if (take && opCode == sleep_op) begin
          pdn_nxt = SLEEP_POWERDOWN;
          to_nxt = SLEEP_TIMEOUT;
          wdClr_nxt = 1'b1;
          preClr_nxt = 1'b1;
          state_nxt = ASLEEP;
        end else if (take && (alu.rotate || isSub)) begin
          // rotate touches only carry; subtracts update all three
          c_nxt = alu.carryOut;
          if (isSub) begin
            digit_nxt = alu.digitOut;
            z_nxt = alu.zeroOut;
          end
          if (opCode == sub_from_literal_op || destBit == DEST_WREG) begin
            w_nxt = alu.result;
          end else begin
            wrEn_nxt = 1'b1;
            wrAddr_nxt = fileAddr;
            wrData_nxt = alu.result;
          end
        end
      end
      ASLEEP: begin
        // the clock block must keep clk alive long enough to see wakeReq
        if (wakeReq) begin
          state_nxt = RUN;
        end
      end
    endcase
  end

  // ==========================================================================
  // core registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RUN;
      w_r <= WREG_RST;
      c_r <= CARRY_RST;
      digit_r <= DIGIT_RST;
      z_r <= ZERO_RST;
      to_r <= TIMEOUT_RST;
      pdn_r <= POWERDOWN_RST;
      wrEn_r <= 1'b0;
      wrAddr_r <= ADDR_RST;
      wrData_r <= WREG_RST;
      wdClr_r <= 1'b0;
      preClr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      w_r <= w_nxt;
      c_r <= c_nxt;
      digit_r <= digit_nxt;
      z_r <= z_nxt;
      to_r <= to_nxt;
      pdn_r <= pdn_nxt;
      wrEn_r <= wrEn_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrData_r <= wrData_nxt;
      wdClr_r <= wdClr_nxt;
      preClr_r <= preClr_nxt;
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign wReg = w_r;
  assign carryFlag = c_r;
  assign digit_carry_flag = digit_r;
  assign zeroFlag = z_r;
  assign timeout_flag = to_r;
  assign powerdown_flag = pdn_r;
  assign fileWrEn = wrEn_r;
  assign fileWrAddr = wrAddr_r;
  assign fileWrData = wrData_r;
  assign watchdogClear = wdClr_r;
  assign prescalerClear = preClr_r;
  assign sleepMode = (state_r == ASLEEP);
  assign oscStop = (state_r == ASLEEP);

  // ==========================================================================
  // checking: snapshot of operands at the taking edge
  logic [DATA_W-1:0] pF_r, pW_r, pL_r;
  logic pC_r, pTake_r, pDest_r;
  op_e pOp_r;
  logic [DATA_W-1:0] pA;
  logic [DATA_W-1:0] expSub;
  logic pBorrow;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pF_r <= WREG_RST;
      pW_r <= WREG_RST;
      pL_r <= WREG_RST;
      pC_r <= CARRY_RST;
      pTake_r <= 1'b0;
      pDest_r <= DEST_WREG;
      pOp_r <= nop_op;
    end else begin
      pF_r <= fileData;
      pW_r <= w_r;
      pL_r <= literal;
      pC_r <= c_r;
      pTake_r <= take;
      pDest_r <= destBit;
      pOp_r <= opCode;
    end
  end

  assign pA = (pOp_r == sub_from_literal_op) ? pL_r : pF_r;
  // borrow in only for the borrow subtract, and only when carry was clear
  assign pBorrow = (pOp_r == sub_with_borrow_op) & ~pC_r;
  assign expSub = pA - pW_r - {{(DATA_W-1){1'b0}}, pBorrow};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rotate_carry: assert property (
    pTake_r && pOp_r == rotate_right_carry_op |-> carryFlag == pF_r[0]
      && zeroFlag == $past(z_r) && digit_carry_flag == $past(digit_r))
    else $error("rotate carry wrong");
  a_rotate_dest: assert property (
    pTake_r && pOp_r == rotate_right_carry_op |->
      (pDest_r ? (fileWrEn && fileWrData == {pC_r, pF_r[DATA_W-1:1]} && wReg == pW_r)
               : (!fileWrEn && wReg == {pC_r, pF_r[DATA_W-1:1]})))
    else $error("rotate result misplaced");
  a_literal_sub: assert property (
    pTake_r && pOp_r == sub_from_literal_op |-> wReg == pL_r - pW_r && !fileWrEn
      && carryFlag == (pW_r <= pL_r))
    else $error("literal subtract wrong");
  a_file_sub_carry: assert property (
    pTake_r && pOp_r == sub_from_file_op |-> carryFlag == (pW_r <= pF_r))
    else $error("subtract carry wrong");
  a_file_sub_dest: assert property (
    pTake_r && pOp_r == sub_from_file_op && pDest_r |->
      fileWrEn && fileWrData == pF_r - pW_r ##1 fileWrEn == (pTake_r && pDest_r
      && pOp_r inside {rotate_right_carry_op, sub_from_file_op, sub_with_borrow_op}))
    else $error("subtract file write wrong");
  a_borrow_sub: assert property (
    pTake_r && pOp_r == sub_with_borrow_op |->
      (pDest_r ? fileWrData : wReg) == expSub
      && carryFlag == ({1'b0, pW_r} + {{DATA_W{1'b0}}, pBorrow} <= {1'b0, pF_r}))
    else $error("borrow subtract wrong");
  a_borrow_dest: assert property (
    pTake_r && pOp_r == sub_with_borrow_op && !pDest_r |-> !fileWrEn && wReg == expSub)
    else $error("borrow subtract misplaced");
  a_sleep_flags: assert property (
    take && opCode == sleep_op |=> !powerdown_flag && timeout_flag)
    else $error("sleep flags wrong");
  a_sleep_watchdog: assert property (
    take && opCode == sleep_op |=> watchdogClear && prescalerClear
      ##1 !watchdogClear && !prescalerClear)
    else $error("watchdog clear pulse wrong");
  a_sleep_state: assert property (
    take && opCode == sleep_op ##1 (!wakeReq)[*2] |-> sleepMode && oscStop)
    else $error("sleep state not held");
  a_zero_digit: assert property (
    pTake_r && (pOp_r == sub_from_file_op || pOp_r == sub_from_literal_op
      || pOp_r == sub_with_borrow_op) |-> zeroFlag == (expSub == ZERO_BYTE)
      && digit_carry_flag == ({1'b0, pW_r[NIB_W-1:0]} + {{NIB_W{1'b0}}, pBorrow}
      <= {1'b0, pA[NIB_W-1:0]}))
    else $error("zero or digit flag wrong");

  c_rotate_file: cover property (take && opCode == rotate_right_carry_op && destBit);
  c_borrow_taken: cover property (take && opCode == sub_with_borrow_op && !carryFlag);
  c_sleep_wake: cover property (sleepMode ##[1:20] !sleepMode);
  c_zero_result: cover property (pTake_r && zeroFlag
    && pOp_r inside {sub_from_literal_op, sub_from_file_op, sub_with_borrow_op});

endmodule // subtract_rotate_sleep_exec

// file: verif/test_subtract_rotate_sleep_exec.sv
// self-checking testbench for the subtract, rotate and sleep execution core
`timescale 1ns/1ps
module test_subtract_rotate_sleep_exec;
  import srs_pkg::*;
  logic clk, arst_n, opValid, destBit, wakeReq;
  op_e opCode;
  logic [ADDR_W-1:0] fileAddr, fileWrAddr;
  logic [DATA_W-1:0] fileData, literal, wReg, fileWrData;
  logic carryFlag, digit_carry_flag, zeroFlag, timeout_flag, powerdown_flag;
  logic fileWrEn, watchdogClear, prescalerClear, sleepMode, oscStop;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'hf612;
  // reference model state
  logic [DATA_W-1:0] mW;
  logic mC, mDigit, mZ, mSleep;

  subtract_rotate_sleep_exec DUT (.clk(clk), .arst_n(arst_n), .opValid(opValid),
    .opCode(opCode), .destBit(destBit), .fileAddr(fileAddr), .fileData(fileData),
    .literal(literal), .wakeReq(wakeReq), .wReg(wReg), .carryFlag(carryFlag),
    .digit_carry_flag(digit_carry_flag), .zeroFlag(zeroFlag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
    .fileWrData(fileWrData), .watchdogClear(watchdogClear), .prescalerClear(prescalerClear),
    .sleepMode(sleepMode), .oscStop(oscStop));

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang in the core would otherwise stall the run forever
  initial begin
    #50000;
    bad_count++;
    final_report();
  end

  // ==========================================================================
  // checking helpers
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // returns {zero, digit, carry, result}; carry and digit mean no borrow
  function automatic logic [10:0] calc(op_e op, logic [7:0] f, logic [7:0] k,
                                       logic [7:0] w, logic c);
    logic [8:0] full;
    logic [4:0] low;
    logic b;
    b = (op == sub_with_borrow_op) ? ~c : 1'b0;
    if (op == sub_from_literal_op) f = k;
    full = {1'b0, f} - {1'b0, w} - {8'h00, b};
    low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, b};
    return {full[7:0] == 8'h00, ~low[4], ~full[8], full[7:0]};
  endfunction

  // one instruction; opValid stays up so callers may go back to back
  task automatic runOp(op_e op, logic d, logic [7:0] f, logic [7:0] k, logic [6:0] a);
    logic [10:0] r;
    logic toFile, live;
    opValid = 1'b1;
    opCode = op;
    destBit = d;
    fileData = f;
    literal = k;
    fileAddr = a;
    @(posedge clk);
    #1;
    live = !mSleep;
    toFile = live && d && (op inside {rotate_right_carry_op, sub_from_file_op,
                                      sub_with_borrow_op});
    if (op == rotate_right_carry_op) r = {mZ, mDigit, f[0], mC, f[7:1]};
    else r = calc(op, f, k, mW, mC);
    if (live && op inside {rotate_right_carry_op, sub_from_literal_op, sub_from_file_op,
                           sub_with_borrow_op}) begin
      if (!toFile) mW = r[7:0];
      {mZ, mDigit, mC} = r[10:8];
    end
    chk("wReg", wReg, mW);
    chk("carryFlag", carryFlag, mC);
    chk("digit_carry_flag", digit_carry_flag, mDigit);
    chk("zeroFlag", zeroFlag, mZ);
    chk("fileWrEn", fileWrEn, toFile);
    if (toFile) begin
      chk("fileWrData", fileWrData, r[7:0]);
      chk("fileWrAddr", fileWrAddr, a);
    end
    chk("watchdogClear", watchdogClear, live && op == sleep_op);
    chk("prescalerClear", prescalerClear, live && op == sleep_op);
    if (live && op == sleep_op) begin
      mSleep = 1'b1;
      chk("powerdown_flag", powerdown_flag, 1'b0);
      chk("timeout_flag", timeout_flag, 1'b1);
    end
    chk("sleepMode", sleepMode, mSleep);
    chk("oscStop", oscStop, mSleep);
  endtask

  // wake request held for one edge, then one idle cycle
  task automatic wake();
    opValid = 1'b0;
    wakeReq = 1'b1;
    @(posedge clk);
    #1;
    mSleep = 1'b0;
    wakeReq = 1'b0;
    chk("sleepMode", sleepMode, 1'b0);
    chk("powerdown_flag", powerdown_flag, 1'b0);
    @(posedge clk);
    #1;
  endtask

  // reset held for two edges; released just after an edge, then reset values checked
  task automatic doReset();
    arst_n = 1'b0;
    {opValid, wakeReq} = '0;
    {mW, mC, mDigit, mZ, mSleep} = '0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("timeout_flag", timeout_flag, TIMEOUT_RST);
    chk("powerdown_flag", powerdown_flag, POWERDOWN_RST);
    chk("sleepMode", sleepMode, 1'b0);
    chk("oscStop", oscStop, 1'b0);
    chk("wReg", wReg, WREG_RST);
    chk("fileWrEn", fileWrEn, 1'b0);
  endtask

  task automatic randOps(int n);
    repeat (n) runOp(op_e'($unsigned($random(seed)) % 5), $random(seed), $random(seed),
                     $random(seed), $random(seed));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // main sequence: corner cases, random traffic, sleep and wake
  initial begin
    {destBit, fileAddr, fileData, literal} = '0;
    opCode = nop_op;
    doReset();
    runOp(sub_from_literal_op, 1'b1, 8'h00, 8'h05, 7'h00);
    runOp(sub_from_file_op, 1'b1, 8'h05, 8'h00, 7'h7f);
    runOp(sub_from_file_op, 1'b0, 8'h03, 8'h00, 7'h01);
    runOp(sub_with_borrow_op, 1'b0, 8'h10, 8'h00, 7'h02);
    runOp(sub_with_borrow_op, 1'b1, 8'hff, 8'h00, 7'h03);
    runOp(rotate_right_carry_op, 1'b0, 8'h81, 8'h00, 7'h04);
    runOp(rotate_right_carry_op, 1'b1, 8'h01, 8'h00, 7'h05);
    runOp(sub_from_literal_op, 1'b0, 8'h00, 8'h00, 7'h00);
    randOps(250);
    runOp(sleep_op, 1'b0, 8'h00, 8'h00, 7'h00);
    runOp(sub_from_file_op, 1'b1, 8'h44, 8'h00, 7'h06);
    runOp(sleep_op, 1'b0, 8'h00, 8'h00, 7'h00);
    wake();
    randOps(40);
    runOp(sleep_op, 1'b0, 8'h00, 8'h00, 7'h00);
    wake();
    // reset while asleep must bring the core back awake with reset flags
    runOp(sleep_op, 1'b0, 8'h00, 8'h00, 7'h00);
    doReset();
    randOps(20);
    final_report();
  end
endmodule // test_subtract_rotate_sleep_exec
